//--- hw/uivm_defines.vh
`ifndef UIVM_DEFINES_VH
`define UIVM_DEFINES_VH

// Vector numbers covered by this block
`define UIVM_FIRST_VECTOR     6'h22
`define UIVM_VECTOR_COUNT     17
`define UIVM_RESERVED_LAST    6'h27
`define UIVM_SW0_VECTOR       6'h28
`define UIVM_SW3_VECTOR       6'h2B
`define UIVM_LOW_SW_VECTOR    6'h2C
`define UIVM_SLOT_ONE_VECTOR  6'h2D
`define UIVM_SLOT_THREE_VECTOR 6'h2F
`define UIVM_SLOT_FOUR_VECTOR 6'h30
`define UIVM_SLOT_SIX_VECTOR  6'h32

// Entry offsets from the vector base (two words per entry)
`define UIVM_LOW_SW_OFFSET    7'h58
`define UIVM_SLOT_ONE_OFFSET  7'h5A
`define UIVM_SLOT_FOUR_OFFSET 7'h60
`define UIVM_SLOT_SIX_OFFSET  7'h64
`define UIVM_WORDS_PER_ENTRY  2
`define UIVM_WATCHDOG_OFFSET  7'h02

// Priority ranks: rank 0 is level -1, rank n+1 is level n
`define UIVM_RANK_LOW_SW      3'h0
`define UIVM_RANK_LEVEL0      3'h1
`define UIVM_RANK_LEVEL1      3'h2
`define UIVM_RANK_LEVEL2      3'h3
`define UIVM_RANK_LEVEL3      3'h4

// Vector base reset value and reachable target width
`define UIVM_BASE_RESET       21'h00_0000
`define UIVM_TARGET_WIDTH     19

`endif

//--- hw/uivm_vector_map.v
// Behaviour
// RQ1 - Each entry spans two words; entry address is base plus twice the vector number.
// RQ2 - Entry targets are limited to a 19-bit program address.
// RQ3 - At the reset base, first two entries coincide with chip and watchdog reset entries.
// RQ4 - Slot six is a fast interrupt unless its entry holds a subroutine jump or branch.
// RQ5 - Vector 44 at offset 0x58 is the software request at level -1.
// RQ6 - Vectors 45 to 47 at offsets 0x5A to 0x5E are slots at level 1.
// RQ7 - Vectors 48 to 50 at offsets 0x60 to 0x64 are slots at level 2.
// RQ8 - Vectors 34-39 reserved at level 0; software 0-3 on 40-43 at levels 0-3.
// RQ9 - Higher level served first; within a level the lowest vector number wins.
// RQ10 - Software puts branches in the first two entries and subroutine jumps elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "uivm_defines.vh"

module uivm_vector_map #(
  parameter ADDR_WIDTH = 21
) (
  // Clock and reset
  input  wire                          ref_clk_in,
  input  wire                          rst_in,
  // Pending requests, bit i is vector 34 + i
  input  wire [`UIVM_VECTOR_COUNT-1:0] request_in,
  // Vector base address
  input  wire [ADDR_WIDTH-1:0]         vector_base_address_in,
  // Words fetched from the selected entry
  input  wire [15:0]                   entry_word0_in,
  input  wire [15:0]                   entry_word1_in,
  input  wire                          subroutine_jump_instruction_in,
  input  wire                          subroutine_branch_instruction_in,
  // Selected request
  output reg                           valid_out,
  output reg  [5:0]                    vector_out,
  output reg  [2:0]                    level_out,
  output reg  [ADDR_WIDTH-1:0]         entry_addr_out,
  output reg                           fast_out,
  output reg  [`UIVM_TARGET_WIDTH-1:0] target_out,
  // Reset entry overlay
  output reg                           overlay_out,
  output reg  [ADDR_WIDTH-1:0]         reset_entry_out,
  output reg  [ADDR_WIDTH-1:0]         watchdog_entry_out
);

  // Sizes of the entry table and of the arbitration result; the address
  // padding below needs ADDR_WIDTH of at least seven bits
  localparam N          = `UIVM_VECTOR_COUNT;
  localparam IDX_WIDTH  = 5;
  localparam RANK_WIDTH = 3;
  localparam VEC_WIDTH  = 6;

  // Rank of each entry and its request after masking reserved vectors
  wire [RANK_WIDTH*N-1:0] rank_flat;
  wire [N-1:0]            live;

  // Fixed priority table, one entry per vector; ranks are constants, so
  // each entry folds down to a plain gate on its request bit
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_entry
      // Vector number, worked out wide and cut to the width of vector_out
      localparam integer VEC_NUM = `UIVM_FIRST_VECTOR + g;
      localparam [VEC_WIDTH-1:0] VEC = VEC_NUM[VEC_WIDTH-1:0];
      // Software requests 0 to 3 sit at levels 0 to 3 in vector order
      localparam integer SW_NUM = VEC_NUM - `UIVM_SW0_VECTOR + 1;
      localparam [RANK_WIDTH-1:0] SW_RANK = SW_NUM[RANK_WIDTH-1:0];
      // Reserved vectors keep a rank but can never be granted
      localparam [0:0] RESERVED = (VEC <= `UIVM_RESERVED_LAST);
      localparam [RANK_WIDTH-1:0] RANK =
        RESERVED                         ? `UIVM_RANK_LEVEL0 : // see RQ8
        (VEC <= `UIVM_SW3_VECTOR)        ? SW_RANK           : // see RQ8
        (VEC == `UIVM_LOW_SW_VECTOR)     ? `UIVM_RANK_LOW_SW : // see RQ5
        (VEC <= `UIVM_SLOT_THREE_VECTOR) ? `UIVM_RANK_LEVEL1 : // see RQ6
                                           `UIVM_RANK_LEVEL2;  // see RQ7
      assign rank_flat[RANK_WIDTH*g +: RANK_WIDTH] = RANK;
      assign live[g] = request_in[g] && !RESERVED; // see RQ8
    end
  endgenerate

  // Arbitration: scan downward so that an equal rank met later, at a lower
  // vector, takes over, and a higher rank always takes over; the winner is
  // the highest level, lowest vector among the live requests
  reg                  next_valid;
  reg [IDX_WIDTH-1:0]  next_index;
  reg [RANK_WIDTH-1:0] best_rank;
  integer              i;
  always @*
  begin
    next_valid = 1'b0;
    next_index = {IDX_WIDTH{1'b0}};
    best_rank  = {RANK_WIDTH{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (live[i]
          && (!next_valid || rank_flat[RANK_WIDTH*i +: RANK_WIDTH] >= best_rank)) // see RQ9
      begin
        next_valid = 1'b1;
        next_index = i[IDX_WIDTH-1:0];
        best_rank  = rank_flat[RANK_WIDTH*i +: RANK_WIDTH];
      end
    end
  end

  // Level code of the winner in two's complement; level -1 reads 3'b111,
  // so software that sign-extends level_out sees the true level
  reg [2:0] next_level;
  always @*
  begin
    case (best_rank)
      `UIVM_RANK_LOW_SW: next_level = 3'h7; // see RQ5
      `UIVM_RANK_LEVEL0: next_level = 3'h0; // see RQ8
      `UIVM_RANK_LEVEL1: next_level = 3'h1; // see RQ6
      `UIVM_RANK_LEVEL2: next_level = 3'h2; // see RQ7
      `UIVM_RANK_LEVEL3: next_level = 3'h3; // see RQ8
      default:           next_level = 3'h0;
    endcase
  end

  // Vector number and entry address of the winner; the entry address is
  // base plus the vector number shifted up one place, two words per entry
  wire [VEC_WIDTH-1:0]  next_vector = `UIVM_FIRST_VECTOR + {1'b0, next_index};
  wire [ADDR_WIDTH-1:0] next_offset = {{(ADDR_WIDTH-VEC_WIDTH-1){1'b0}},
                                       next_vector, 1'b0}; // see RQ1
  wire [ADDR_WIDTH-1:0] next_entry  = vector_base_address_in + next_offset; // see RQ1

  // Slot six counts as fast only when it wins and its entry holds neither
  // kind of subroutine call; a call there means an ordinary vectored entry
  wire next_is_slot_six = next_valid && (next_vector == `UIVM_SLOT_SIX_VECTOR);
  wire next_is_call     = subroutine_jump_instruction_in || subroutine_branch_instruction_in;
  wire next_fast        = next_is_slot_six && !next_is_call; // see RQ4

  // Reachable target: three low bits of the first word above the second word;
  // anything above bit 18 of a program address cannot be named by an entry
  wire [`UIVM_TARGET_WIDTH-1:0] next_target = {entry_word0_in[2:0], entry_word1_in}; // see RQ2

  // Reset overlay: the chip reset entry is the base, the watchdog entry the
  // next pair of words; they coincide with entries 0 and 1 at the reset base
  wire                  next_overlay    = (vector_base_address_in == `UIVM_BASE_RESET); // see RQ3
  wire [ADDR_WIDTH-1:0] watchdog_offset = {{(ADDR_WIDTH-7){1'b0}}, `UIVM_WATCHDOG_OFFSET};
  wire [ADDR_WIDTH-1:0] next_watchdog   = vector_base_address_in + watchdog_offset; // see RQ3

  // Arbitration result registers; all read zero while nothing is pending
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      valid_out  <= 1'b0;
      vector_out <= {VEC_WIDTH{1'b0}};
      level_out  <= 3'h0;
    end
    else if (next_valid)
    begin
      valid_out  <= 1'b1;
      vector_out <= next_vector;
      level_out  <= next_level;
    end
    else
    begin
      valid_out  <= 1'b0;
      vector_out <= {VEC_WIDTH{1'b0}};
      level_out  <= 3'h0;
    end
  end

  // Entry address register; cleared when no request wins, so a stale
  // address never reaches the core beside a low valid_out
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      entry_addr_out <= {ADDR_WIDTH{1'b0}};
    end
    else if (next_valid)
    begin
      entry_addr_out <= next_entry; // see RQ1
    end
    else
    begin
      entry_addr_out <= {ADDR_WIDTH{1'b0}};
    end
  end

  // Fast flag register; it follows the winner, so a slot six that loses
  // arbitration is never reported fast
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      fast_out <= 1'b0;
    end
    else
    begin
      fast_out <= next_fast; // see RQ4
    end
  end

  // Target register; it tracks the fetched words on every edge, winner
  // or not, so the core reads it in the cycle after its fetch
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      target_out <= {`UIVM_TARGET_WIDTH{1'b0}};
    end
    else
    begin
      target_out <= next_target; // see RQ2
    end
  end

  // Reset overlay registers, recomputed from the base on every edge
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      overlay_out        <= 1'b0;
      reset_entry_out    <= {ADDR_WIDTH{1'b0}};
      watchdog_entry_out <= {ADDR_WIDTH{1'b0}};
    end
    else
    begin
      overlay_out        <= next_overlay;           // see RQ3
      reset_entry_out    <= vector_base_address_in; // see RQ3
      watchdog_entry_out <= next_watchdog;          // see RQ3
    end
  end

endmodule
`default_nettype wire

//--- tb/uivm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module uivm_chk #(parameter ADDR_WIDTH = 21) (
  input wire logic ref_clk_in, rst_in, valid_out, fast_out, overlay_out,
  input wire logic subroutine_jump_instruction_in, subroutine_branch_instruction_in,
  input wire logic [16:0] request_in,
  input wire logic [15:0] entry_word0_in, entry_word1_in,
  input wire logic [5:0] vector_out,
  input wire logic [2:0] level_out,
  input wire logic [18:0] target_out,
  input wire logic [ADDR_WIDTH-1:0] vector_base_address_in, entry_addr_out,
  input wire logic [ADDR_WIDTH-1:0] reset_entry_out, watchdog_entry_out);
  logic live = 1'b0;
  // Outputs count only once an unreset edge has loaded them
  always @(posedge ref_clk_in) live <= !rst_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_entry_addr: assert property (
    live && valid_out |-> entry_addr_out == $past(vector_base_address_in) + {vector_out, 1'b0})
    else $error("bad entry address");
  a_target_pack: assert property (
    live |-> target_out == {$past(entry_word0_in[2:0]), $past(entry_word1_in)}) else $error("bad target");
  a_reset_overlay: assert property (
    live |-> overlay_out == ($past(vector_base_address_in) == 0)
    && watchdog_entry_out == ADDR_WIDTH'(reset_entry_out + 2)) else $error("bad overlay");
  a_fast_slot: assert property (
    live |-> fast_out == (valid_out && vector_out == 50 && !$past(subroutine_jump_instruction_in)
    && !$past(subroutine_branch_instruction_in))) else $error("bad fast flag");
  a_lowest_level: assert property (
    valid_out && vector_out == 44 |-> level_out == 3'h7) else $error("bad level -1");
  a_level_one: assert property (
    valid_out && vector_out inside {[45:47]} |-> level_out == 3'h1) else $error("bad level 1");
  a_level_two: assert property (
    valid_out && vector_out inside {[48:50]} |-> level_out == 3'h2) else $error("bad level 2");
  a_no_reserved: assert property (
    live |-> valid_out == |($past(request_in) & 17'h1_ffc0)) else $error("bad valid");
  a_winner_pending: assert property (
    live && valid_out |-> |(($past(request_in) >> (vector_out - 6'h22)) & 17'h0_0001))
    else $error("winner not pending");
  c_fast: cover property (fast_out);
  c_low: cover property (valid_out && level_out == 3'h7);
  c_overlay: cover property (overlay_out && valid_out);
endmodule
bind uivm_vector_map uivm_chk #(.ADDR_WIDTH(ADDR_WIDTH)) uivm_chk_i (.*);
`default_nettype wire

//--- tb/uivm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fetched entry: kind 0 subroutine jump, 1 subroutine branch, 2 plain fast code
module uivm_core_model (
  input  wire logic [1:0]  kind_in,
  input  wire logic [20:0] addr_in,
  output logic      [15:0] word0_out, word1_out,
  output logic             jump_out, branch_out);
  // Words follow the fetch address so the packed target is traceable
  assign word0_out = addr_in[15:0];
  assign word1_out = addr_in[20:5] ^ 16'h5a5a;
  assign jump_out = kind_in == 2'h0;
  assign branch_out = kind_in == 2'h1;
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk_in = 0, rst_in = 1, valid_out, fast_out, overlay_out;
  logic subroutine_jump_instruction_in, subroutine_branch_instruction_in;
  logic [16:0] request_in = 0;
  logic [20:0] vector_base_address_in = 0, fetch = 0, entry_addr_out, reset_entry_out;
  logic [20:0] watchdog_entry_out;
  logic [15:0] entry_word0_in, entry_word1_in;
  logic [5:0] vector_out;
  logic [2:0] level_out;
  logic [18:0] target_out;
  logic [1:0] kind = 0;
  int err_total = 0, n_compared = 0, t, n, v;
  // 40 MHz clock
  always #12.5 ref_clk_in = ~ref_clk_in;
  uivm_core_model uivm_core_model_i (.kind_in(kind), .addr_in(fetch), .word0_out(entry_word0_in),
    .word1_out(entry_word1_in), .jump_out(subroutine_jump_instruction_in),
    .branch_out(subroutine_branch_instruction_in));
  uivm_vector_map uivm_vector_map_i (.*);
  function automatic int lv(int i);
    return i < 10 ? i - 6 : i == 10 ? -1 : i < 14 ? 1 : 2;
  endfunction
  task automatic chk(input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Tests: random mix, reset base, slot six alone
  initial
  begin
    void'($urandom(26734));
    repeat (4) @(negedge ref_clk_in);
    rst_in = 0;
    for (t = 0; t < 3; t++)
    begin
      for (n = 0; n < 200; n++)
      begin
        request_in = (t == 2 && $urandom % 2) ? 17'h1_0000 : $urandom & $urandom;
        vector_base_address_in = t == 1 ? 0 : $urandom;
        fetch = $urandom;
        kind = $urandom % 3;
        @(negedge ref_clk_in);
        v = -1;
        for (int i = 16; i >= 6; i--) if (request_in[i] && (v < 0 || lv(i) >= lv(v))) v = i;
        chk({valid_out, vector_out, level_out}, v < 0 ? 0 : {1'b1, 6'(34 + v), 3'(lv(v))});
        chk(entry_addr_out, v < 0 ? 0 : 21'(vector_base_address_in + 68 + 2 * v));
        chk(target_out, {entry_word0_in[2:0], entry_word1_in});
        chk(fast_out, v == 16 && kind == 2);
        chk({overlay_out, reset_entry_out, watchdog_entry_out}, {vector_base_address_in == 0,
          vector_base_address_in, 21'(vector_base_address_in + 2)});
      end
      $display("test %0d done", t);
    end
    end_sim;
  end
  // Cut a hang short
  initial
  begin
    #50000;
    err_total++;
    end_sim;
  end
endmodule
`default_nettype wire
